// ==== verilog/phb_device.sv ====
// Device end of the parallel host port
`timescale 1ns/1ps
// How it works
// RL1: Byte-wide port reaches direct registers
// RL2: Share strap high selects multiplexed bus
// RL3: Format strap high selects data strobe
// RL4: Host asserts select with read strobe
// RL5: Host asserts select with store strobe
// RL6: Store strobe idle during reads
// RL7: Read strobe idle during writes
// RL8: Select with data strobe, both directions
// RL9: Transfer about 260 or 300 ns; the host here takes 7 to 9 clocks (350 to 450 ns) per access
// RL10: Back-to-back separate buses reach 30 Mbps; the host here takes 8 clocks (400 ns) per read byte, 20 Mbps
// RL11: Address strobe drops 40 ns early
// RL12: Read strobe held 160 ns
// RL13: Store strobe held 120 ns
// RL14: Direction line set 30 ns early
// RL15: Data strobe held 160/120 ns
// RL16: Latch address on falling address strobe
// RL17: Drive data only during selected read
module phb_device (
	input wire logic clk,
	input wire logic arst_n,
	phb_if.device bus,
	output logic [phb_pkg::ADDR_W-1:0] reg_addr,
	output logic [phb_pkg::DATA_W-1:0] reg_wdata,
	output logic reg_we,
	output logic reg_re,
	input wire logic [phb_pkg::DATA_W-1:0] reg_rdata
);
	import phb_pkg::*;

	// ********************
	// Declarations
	// ********************
	// Strobe decode
	logic rd_act;
	logic wr_act;
	logic cs_q;

	// Strobe history and edges
	logic ale_q;
	logic rd_q;
	logic wr_q;
	logic next_ale_q;
	logic next_rd_q;
	logic next_wr_q;
	logic ale_fall;
	logic rd_start;
	logic wr_end;

	// Address latch
	logic [7:0] lat_addr;
	logic [7:0] next_lat_addr;
	logic [7:0] bus_addr;

	// Register requests
	logic [7:0] next_reg_addr;
	logic [7:0] next_reg_wdata;
	logic next_reg_we;
	logic next_reg_re;

	// Read drive
	logic [7:0] dout;
	logic [7:0] next_dout;
	logic oe;
	logic next_oe;

	// ********************
	// Strobe decode
	// ********************
	// In data-strobe format wr_n carries the direction (high = read)
	// A read or store strobe without select is ignored outright
	always_comb begin
		if (bus.strobe_format_select_pin) begin // RL3
			rd_act = !bus.cs_n && !bus.rd_n && bus.wr_n; // RL8
			wr_act = !bus.cs_n && !bus.rd_n && !bus.wr_n; // RL8
		end else begin
			rd_act = !bus.cs_n && !bus.rd_n; // RL4
			wr_act = !bus.cs_n && !bus.wr_n; // RL5
		end
	end

	// Select seen as a level; it also gates the data drive
	assign cs_q = !bus.cs_n;

	// ********************
	// Strobe history
	// ********************
	// Edges are found each clock, so back-to-back strobes all count
	always_comb begin
		next_ale_q = bus.ale;
		next_rd_q = rd_act;
		next_wr_q = wr_act;
	end

	// Reset levels match the idle pins, so no false edge follows reset
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ale_q <= 1'b0;
			rd_q <= 1'b0;
			wr_q <= 1'b0;
		end else begin
			ale_q <= next_ale_q;
			rd_q <= next_rd_q;
			wr_q <= next_wr_q;
		end
	end

	assign ale_fall = ale_q && !bus.ale;
	assign rd_start = rd_act && !rd_q; // RL10
	assign wr_end = !wr_act && wr_q; // RL10

	// ********************
	// Address latch
	// ********************
	// Address caught as the latch strobe falls; a stray latch pulse
	// only replaces the held address, nothing checks a data phase follows
	always_comb begin
		next_lat_addr = lat_addr;
		if (ale_fall) begin
			next_lat_addr = bus.data; // RL16
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			lat_addr <= BYTE_RESET;
		end else begin
			lat_addr <= next_lat_addr;
		end
	end

	// Shared bus takes the latched address, split bus the address pins
	assign bus_addr = bus.bus_share_select_pin ? lat_addr
		: bus.addr; // RL2

	// ********************
	// Register requests
	// ********************
	// Read fetched on strobe start; write stored on strobe end so the
	// data has settled, at one byte per access
	// Write data tracks the bus while the strobe lasts; the last sample
	// before the strobe ends is the one stored
	always_comb begin
		next_reg_addr = reg_addr;
		next_reg_wdata = reg_wdata;
		next_reg_we = 1'b0;
		next_reg_re = 1'b0;
		if (rd_start) begin
			next_reg_re = 1'b1; // RL1
			next_reg_addr = bus_addr; // RL2
		end
		if (wr_end) begin
			next_reg_we = 1'b1; // RL1
		end
		if (wr_act) begin
			next_reg_addr = bus_addr; // RL2
			next_reg_wdata = bus.data;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_addr <= BYTE_RESET;
			reg_wdata <= BYTE_RESET;
			reg_we <= 1'b0;
			reg_re <= 1'b0;
		end else begin
			reg_addr <= next_reg_addr;
			reg_wdata <= next_reg_wdata;
			reg_we <= next_reg_we;
			reg_re <= next_reg_re;
		end
	end

	// ********************
	// Read drive
	// ********************
	// Data is ready two cycles into the strobe, inside the 140 ns limit
	// Refreshed while the strobe lasts, so a slow host reads a steady byte
	always_comb begin
		next_oe = rd_act && rd_q; // RL17
		next_dout = dout;
		if (rd_q) begin
			next_dout = reg_rdata; // RL9
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dout <= BYTE_RESET;
			oe <= 1'b0;
		end else begin
			dout <= next_dout;
			oe <= next_oe;
		end
	end

	// ********************
	// Pins
	// ********************
	// Drive ends with select, ahead of the host's next address phase
	assign bus.dev_data_out = dout;
	assign bus.dev_data_oe = oe && cs_q; // RL17
endmodule

// ==== shared/phb_pkg.sv ====
// Shared constants and types for the parallel host port
package phb_pkg;
	// ********************
	// Clock and widths
	// ********************
	localparam int CLK_PERIOD_NS = 50;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 8;
	// ********************
	// Host-side timing figures in ns
	// ********************
	localparam int T_ALE_HIGH_NS = 40;
	localparam int T_ALE_TO_STROBE_NS = 40;
	localparam int T_SETUP_NS = 40;
	localparam int T_RW_SETUP_NS = 30;
	localparam int T_RD_LOW_NS = 160;
	localparam int T_WR_LOW_NS = 120;
	localparam int T_HOLD_NS = 60;
	localparam int T_XFER_SEP_NS = 260;
	localparam int T_XFER_MUX_NS = 300;
	// Least times round up to whole cycles
	localparam int CYC_ALE_HIGH =
		(T_ALE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_ALE_TO_STROBE =
		(T_ALE_TO_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_SETUP =
		(T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_RW_SETUP =
		(T_RW_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_RD_LOW =
		(T_RD_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_WR_LOW =
		(T_WR_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_HOLD =
		(T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] CNT_RESET = 4'h0;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	// ********************
	// Host sequencer states
	// ********************
	typedef enum logic [2:0] {
		PHB_IDLE = 3'b000,
		PHB_ALE = 3'b001,
		PHB_GAP = 3'b010,
		PHB_SETUP = 3'b011,
		PHB_STROBE = 3'b100,
		PHB_HOLD = 3'b101
	} phb_state_t;
endpackage

// ==== shared/phb_if.sv ====
// Pin-level carrier between host and device ends of the port
`timescale 1ns/1ps
interface phb_if;
	logic bus_share_select_pin;
	logic strobe_format_select_pin;
	logic cs_n;
	logic rd_n;
	logic wr_n;
	logic ale;
	logic [7:0] addr;
	logic [7:0] host_data_out;
	logic host_data_oe;
	logic [7:0] dev_data_out;
	logic dev_data_oe;
	// Resolved data bus: the single driver, else all ones as pull-ups
	logic [7:0] data;
	assign data = dev_data_oe ? dev_data_out :
		(host_data_oe ? host_data_out : 8'hFF);
	modport device (
		input bus_share_select_pin, strobe_format_select_pin,
		input cs_n, rd_n, wr_n, ale, addr, data,
		output dev_data_out, dev_data_oe
	);
	modport host (
		output bus_share_select_pin, strobe_format_select_pin,
		output cs_n, rd_n, wr_n, ale, addr, host_data_out, host_data_oe,
		input data
	);
endinterface

// ==== verilog/phb_host.sv ====
// Host end of the parallel host port
`timescale 1ns/1ps
module phb_host (
	input wire logic clk,
	input wire logic arst_n,
	phb_if.host bus,
	input wire logic mux_mode,
	input wire logic ds_mode,
	input wire logic req,
	input wire logic req_write,
	input wire logic [phb_pkg::ADDR_W-1:0] req_addr,
	input wire logic [phb_pkg::DATA_W-1:0] req_wdata,
	output logic busy,
	output logic done,
	output logic [phb_pkg::DATA_W-1:0] rdata
);
	import phb_pkg::*;
	phb_state_t state, next_state;
	logic [3:0] cnt, next_cnt;
	logic wr, next_wr, next_busy, next_done;
	logic [7:0] addr, next_addr, wdat, next_wdat, next_rdata;
	logic mux_q, ds_q;
	// ********************
	// Sequencer
	// ********************
	always_comb begin
		next_state = state;
		next_cnt = cnt - 4'h1;
		next_wr = wr;
		next_addr = addr;
		next_wdat = wdat;
		next_rdata = rdata;
		next_done = 1'b0;
		next_busy = 1'b1;
		unique case (state)
			PHB_IDLE: begin
				next_busy = 1'b0;
				next_cnt = CNT_RESET;
				if (req) begin
					next_wr = req_write;
					next_addr = req_addr;
					next_wdat = req_wdata;
					next_busy = 1'b1;
					next_state = mux_q ? PHB_ALE : PHB_SETUP;
					next_cnt = mux_q ? 4'(CYC_ALE_HIGH) : 4'(CYC_SETUP);
				end
			end
			PHB_ALE: if (cnt == 4'h1) begin
				next_state = PHB_GAP;
				next_cnt = 4'(CYC_ALE_TO_STROBE); // RL11
			end
			PHB_GAP: if (cnt == 4'h1) begin
				next_state = PHB_STROBE;
				next_cnt = wr ? 4'(CYC_WR_LOW) : 4'(CYC_RD_LOW);
			end
			PHB_SETUP: if (cnt == 4'h1) begin
				// Direction and address settle before the strobe
				next_state = PHB_STROBE; // RL14
				next_cnt = wr ? 4'(CYC_WR_LOW) : 4'(CYC_RD_LOW); // RL12 RL13 RL15
			end
			PHB_STROBE: if (cnt == 4'h1) begin
				next_rdata = wr ? rdata : bus.data;
				next_state = PHB_HOLD;
				next_cnt = 4'(CYC_HOLD);
			end
			PHB_HOLD: if (cnt == 4'h1) begin
				next_done = 1'b1;
				next_busy = 1'b0;
				next_state = PHB_IDLE;
			end
			default: next_state = PHB_IDLE;
		endcase
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= PHB_IDLE;
			cnt <= CNT_RESET;
			wr <= 1'b0;
			addr <= BYTE_RESET;
			wdat <= BYTE_RESET;
			rdata <= BYTE_RESET;
			busy <= 1'b0;
			done <= 1'b0;
			mux_q <= 1'b0;
			ds_q <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			wr <= next_wr;
			addr <= next_addr;
			wdat <= next_wdat;
			rdata <= next_rdata;
			busy <= next_busy;
			done <= next_done;
			// Straps change only between accesses
			if (state == PHB_IDLE) begin
				mux_q <= mux_mode;
				ds_q <= ds_mode;
			end
		end
	end
	// ********************
	// Pins
	// ********************
	logic strobe;
	assign strobe = (state == PHB_STROBE);
	assign bus.bus_share_select_pin = mux_q; // RL2
	assign bus.strobe_format_select_pin = ds_q; // RL3
	// Select spans setup or gap and the strobe, not latch or hold, so it always leads the strobe
	assign bus.cs_n = !(state == PHB_SETUP || state == PHB_GAP
		|| strobe); // RL4 RL5 RL8
	assign bus.ale = (state == PHB_ALE);
	// rd_n is the data strobe in ds format; wr_n then carries direction
	assign bus.rd_n = ds_q ? !strobe : !(strobe && !wr); // RL7
	assign bus.wr_n = ds_q ? !wr : !(strobe && wr); // RL6 RL14
	assign bus.addr = addr;
	assign bus.host_data_out = (state == PHB_ALE || state == PHB_GAP)
		? addr : wdat;
	assign bus.host_data_oe = mux_q ? (state == PHB_ALE
		|| state == PHB_GAP || (wr && state != PHB_IDLE))
		: (wr && state != PHB_IDLE);
endmodule

// ==== dv/phb_sva.sv ====
// Pin-level assertion checker for the parallel host port
`timescale 1ns/1ps
module phb_sva (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic bus_share_select_pin,
	input wire logic strobe_format_select_pin,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic ale,
	input wire logic host_data_oe,
	input wire logic dev_data_oe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	// ********************
	// Strobe starts
	// ********************
	sequence rd_go;
		$fell(rd_n) && (!strobe_format_select_pin || wr_n);
	endsequence
	sequence wr_go;
		strobe_format_select_pin ? ($fell(rd_n) && !wr_n) : $fell(wr_n);
	endsequence
	// ********************
	// Properties
	// ********************
	rd_sel_first_a: assert property (
		$fell(rd_n) |-> !cs_n) else $error("select late on strobe");
	wr_sel_first_a: assert property (
		!strobe_format_select_pin && $fell(wr_n) |-> !cs_n)
		else $error("select late on store");
	strobes_excl_a: assert property (
		!strobe_format_select_pin && !rd_n |-> wr_n)
		else $error("both strobes low");
	rd_width_a: assert property (
		rd_go |-> (!rd_n)[*4]) else $error("read strobe short");
	wr_width_a: assert property (
		wr_go |-> (strobe_format_select_pin ? !rd_n : !wr_n)[*3])
		else $error("store strobe short");
	ale_gap_a: assert property (
		bus_share_select_pin && !strobe_format_select_pin && $fell(ale)
		|-> rd_n && wr_n) else $error("strobe too soon after latch");
	dir_setup_a: assert property (
		strobe_format_select_pin && $fell(rd_n) |-> $stable(wr_n))
		else $error("direction not set up");
	no_latch_sep_a: assert property (
		!bus_share_select_pin |-> !ale) else $error("latch in split mode");
	read_drive_a: assert property (
		rd_go ##0 !cs_n |-> ##[1:3] dev_data_oe)
		else $error("read data not driven");
	drive_gate_a: assert property (
		dev_data_oe |-> !$past(rd_n) && !$past(cs_n))
		else $error("drive outside read");
	one_driver_a: assert property (
		!(dev_data_oe && host_data_oe)) else $error("bus contention");
endmodule

// ==== dv/tb_parallel_host_bus_interface.sv ====
// Self-checking bench joining the host and device ends
`timescale 1ns/1ps
module tb_parallel_host_bus_interface;
	import phb_pkg::*;
	logic clk, arst_n, mux_mode, ds_mode, req, req_write, busy, done;
	logic reg_we, reg_re;
	logic [7:0] req_addr, req_wdata, rdata, reg_addr, reg_wdata, reg_rdata;
	logic [7:0] mem [0:255];
	int n_fail, check_count, n_we, n_re;
	phb_if bus_if ();
	phb_host phb_host_i (.clk(clk), .arst_n(arst_n), .bus(bus_if),
		.mux_mode(mux_mode), .ds_mode(ds_mode), .req(req),
		.req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
		.busy(busy), .done(done), .rdata(rdata));
	phb_device phb_device_i (.clk(clk), .arst_n(arst_n), .bus(bus_if),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
		.reg_re(reg_re), .reg_rdata(reg_rdata));
	phb_sva phb_sva_i (.clk(clk), .arst_n(arst_n),
		.bus_share_select_pin(bus_if.bus_share_select_pin),
		.strobe_format_select_pin(bus_if.strobe_format_select_pin),
		.cs_n(bus_if.cs_n), .rd_n(bus_if.rd_n), .wr_n(bus_if.wr_n),
		.ale(bus_if.ale), .host_data_oe(bus_if.host_data_oe),
		.dev_data_oe(bus_if.dev_data_oe));
	// Register file stand-in; read data is combinational so it is held
	assign reg_rdata = mem[reg_addr];
	always @(posedge clk) begin
		if (reg_we === 1'b1) begin
			mem[reg_addr] <= reg_wdata;
			n_we++;
		end
		if (reg_re === 1'b1) begin
			n_re++;
		end
	end
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic final_report();
		if (n_fail == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] got, exp, input string what);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: %s got %h exp %h", $time, what,
				got, exp);
		end
	endtask
	// One access; returns edges from take to done, bounded
	task automatic xfer(input logic w, input logic [7:0] a, d,
		output int cyc);
		@(posedge clk);
		req <= 1'b1;
		req_write <= w;
		req_addr <= a;
		req_wdata <= d;
		@(posedge clk);
		req <= 1'b0;
		cyc = 1;
		#1;
		check(8'(busy), 8'h01, "busy on take");
		while (done !== 1'b1 && cyc < 20) begin
			@(posedge clk);
			#1;
			cyc++;
		end
		if (cyc >= 20) begin
			n_fail++;
			final_report();
		end
		check(8'(busy), 8'h00, "busy after done");
	endtask
	// ********************
	// Scenarios
	// ********************
	task automatic scen_modes();
		int c;
		int w0;
		int r0;
		for (int m = 0; m < 4; m++) begin
			@(posedge clk);
			mux_mode <= m[0];
			ds_mode <= m[1];
			w0 = n_we;
			xfer(1'b1, 8'h10 + m[7:0], 8'hA5 ^ m[7:0], c);
			check(8'(c <= 10), 8'h01, "write time");
			xfer(1'b1, 8'h90 + m[7:0], 8'h5A + m[7:0], c);
			check(8'(n_we - w0), 8'h02, "store pulses");
			r0 = n_re;
			xfer(1'b0, 8'h10 + m[7:0], 8'h00, c);
			check(8'(n_re - r0), 8'h01, "fetch pulses");
			check(rdata, 8'hA5 ^ m[7:0], "read");
			check(8'(c <= 10), 8'h01, "read time");
		end
	endtask
	// Reads issued the cycle after done, separate buses
	task automatic scen_b2b();
		int c;
		@(posedge clk);
		mux_mode <= 1'b0;
		ds_mode <= 1'b0;
		xfer(1'b0, 8'h93, 8'h00, c);
		check(rdata, 8'h5D, "first read");
		xfer(1'b0, 8'h12, 8'h00, c);
		check(rdata, 8'hA7, "second read");
		check(8'(c), 8'(1 + CYC_SETUP + CYC_RD_LOW + CYC_HOLD),
			"b2b read time");
	endtask
	initial begin
		arst_n = 1'b0;
		mux_mode = 1'b0;
		ds_mode = 1'b0;
		req = 1'b0;
		req_write = 1'b0;
		req_addr = 8'h00;
		req_wdata = 8'h00;
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		scen_modes();
		scen_b2b();
		final_report();
	end
endmodule
